// file: rtl/qesr_cfg.svh
`ifndef QESR_CFG_SVH
`define QESR_CFG_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define QESR_OFF_EVT_BASE  12'h100
`define QESR_EVT_STRIDE    12'h004
`define QESR_OFF_HALTED    12'h110
`define QESR_OFF_LINKS     12'h200
`define QESR_OFF_EN_SET    12'h304
`define QESR_OFF_EN_CLR    12'h308
`define QESR_OFF_STATUS    12'h30c
`define QESR_OFF_STAT_CLR  12'h310

// ----------------------------------------------------------------
// widths, reset values, responses
// ----------------------------------------------------------------
`define QESR_ADDR_W        12
`define QESR_NUM_EVT       5
`define QESR_NUM_LINK      7
`define QESR_RST_WORD      32'h0000_0000
`define QESR_RESP_OKAY     2'h0
`define QESR_RESP_SLVERR   2'h2

`endif

// file: rtl/qesr_pkg.sv
package qesr_pkg;

    // bit 0 = sample ready ... bit 4 = halted
    typedef struct packed {
        logic halted;
        logic double_ready;
        logic accumulator_overflow;
        logic report_ready;
        logic sample_ready;
    } qesr_evt_type;

    // bit 0 = field A ... bit 6 = field G
    typedef struct packed {
        logic sample_read_clear;
        logic double_stop;
        logic double_read_clear_dbl;
        logic report_stop;
        logic report_alt_read_clear;
        logic sample_stop;
        logic report_read_clear;
    } qesr_link_type;

    typedef struct packed {
        logic read_clear_accumulator;
        logic alt_read_clear_accumulator;
        logic read_clear_double_accumulator;
        logic stop;
    } qesr_task_type;

endpackage

// file: rtl/qesr_regs.sv
// What this block does
// - halted event sets a flag readable at 0x110, 1 once raised
// - shortcut register at 0x200, one enable bit per link, resets to zero
// - field A: report ready fires read-and-clear accumulator task
// - field B: sample ready fires stop task
// - field C: report ready fires alternate read-and-clear task
// - field D: report ready fires stop task
// - field E: double ready fires read-and-clear double accumulator task
// - field F: double ready fires stop task
// - field G: sample ready fires read-and-clear accumulator task
// - writing 1 to enable-set enables that interrupt; 0 leaves it
// - enable bits: A sample, B report, C overflow, D double, E halted
// - enable-set reads current enables; all reset disabled
// - report ready only at period end with motion accumulator nonzero
// - double ready only at period end with double accumulator nonzero
// - writing 1 to enable-clear disables; it reads like enable-set
// - sample ready raised for each new sample written
`timescale 1ns/1ps
`default_nettype none
`include "qesr_cfg.svh"

module qesr_regs
    import qesr_pkg::*;
(
    // clock and reset
    input  wire logic                    mclk,
    input  wire logic                    rst,
    // axi4-lite write address
    input  wire logic [`QESR_ADDR_W-1:0] s_awaddr,
    input  wire logic                    s_awvalid,
    output logic                         s_awready,
    // axi4-lite write data
    input  wire logic [31:0]             s_wdata,
    input  wire logic [3:0]              s_wstrb,
    input  wire logic                    s_wvalid,
    output logic                         s_wready,
    // axi4-lite write response
    output logic [1:0]                   s_bresp,
    output logic                         s_bvalid,
    input  wire logic                    s_bready,
    // axi4-lite read
    input  wire logic [`QESR_ADDR_W-1:0] s_araddr,
    input  wire logic                    s_arvalid,
    output logic                         s_arready,
    output logic [31:0]                  s_rdata,
    output logic [1:0]                   s_rresp,
    output logic                         s_rvalid,
    input  wire logic                    s_rready,
    // decoder datapath status
    input  wire logic                    sample_written,
    input  wire logic                    period_done,
    input  wire logic                    acc_nonzero,
    input  wire logic                    dbl_nonzero,
    input  wire logic                    acc_overflow,
    input  wire logic                    decoder_halted,
    // events and tasks to the decoder
    output qesr_evt_type                 evt_pulse,
    output qesr_task_type                task_pulse,
    output logic                         irq
);

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function automatic logic [`QESR_ADDR_W-1:0] evt_off(input int i);
        return `QESR_OFF_EVT_BASE + `QESR_EVT_STRIDE * (`QESR_ADDR_W)'(i);
    endfunction

    function automatic logic is_mapped(input logic [`QESR_ADDR_W-1:0] a);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < `QESR_NUM_EVT; i++)
        begin
            if (a == evt_off(i))
                hit = 1'b1;
        end
        if (a == `QESR_OFF_LINKS || a == `QESR_OFF_EN_SET || a == `QESR_OFF_EN_CLR ||
            a == `QESR_OFF_STATUS || a == `QESR_OFF_STAT_CLR)
            hit = 1'b1;
        return hit;
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    qesr_evt_type             flags_q;
    qesr_evt_type             en_q;
    qesr_link_type            links_q;
    qesr_evt_type             evt_q;
    qesr_task_type            task_q;
    qesr_evt_type             evt_now;
    logic                     irq_q;
    logic [`QESR_ADDR_W-1:0]  awaddr_q;
    logic [31:0]              wdata_q;
    logic [3:0]               wstrb_q;
    logic                     aw_full_q;
    logic                     w_full_q;
    logic                     awready_q;
    logic                     wready_q;
    logic                     bvalid_q;
    logic [1:0]               bresp_q;
    logic                     arready_q;
    logic                     rvalid_q;
    logic [31:0]              rdata_q;
    logic [1:0]               rresp_q;
    logic                     do_wr;
    logic                     b_done;
    logic                     wr_lo;
    logic [31:0]              rd_word;

    assign do_wr  = aw_full_q & w_full_q & ~bvalid_q;
    assign b_done = bvalid_q & s_bready;
    assign wr_lo  = do_wr & wstrb_q[0];

    // ----------------------------------------------------------------
    // event generation
    // ----------------------------------------------------------------
    always_comb
    begin
        evt_now = '0;
        evt_now.sample_ready = sample_written;
        evt_now.report_ready = period_done & acc_nonzero;
        evt_now.accumulator_overflow = acc_overflow;
        evt_now.double_ready = period_done & dbl_nonzero;
        evt_now.halted = decoder_halted;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            evt_q <= '0;
        else
            evt_q <= evt_now;
    end

    // ----------------------------------------------------------------
    // shortcuts from events to tasks
    // ----------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst)
            task_q <= '0;
        else
        begin
            task_q.read_clear_accumulator <=
                (evt_now.report_ready & links_q.report_read_clear) |
                (evt_now.sample_ready & links_q.sample_read_clear);
            task_q.alt_read_clear_accumulator <=
                evt_now.report_ready & links_q.report_alt_read_clear;
            task_q.read_clear_double_accumulator <=
                evt_now.double_ready & links_q.double_read_clear_dbl;
            task_q.stop <= (evt_now.sample_ready & links_q.sample_stop) |
                           (evt_now.report_ready & links_q.report_stop) |
                           (evt_now.double_ready & links_q.double_stop);
        end
    end

    // ----------------------------------------------------------------
    // event flags
    // ----------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst)
            flags_q <= '0;
        else
        begin
            for (int i = 0; i < `QESR_NUM_EVT; i++)
            begin
                // flag set wins over software clear
                if (wr_lo && awaddr_q == evt_off(i))
                    flags_q[i] <= wdata_q[0] | evt_now[i];
                else if (wr_lo && awaddr_q == `QESR_OFF_STAT_CLR)
                    flags_q[i] <= (flags_q[i] & ~wdata_q[i]) | evt_now[i];
                else
                    flags_q[i] <= flags_q[i] | evt_now[i];
            end
        end
    end

    // ----------------------------------------------------------------
    // shortcut and interrupt enable registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst)
            links_q <= '0;
        else if (wr_lo && awaddr_q == `QESR_OFF_LINKS)
            links_q <= wdata_q[`QESR_NUM_LINK-1:0];
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            en_q <= '0;
        else if (wr_lo && awaddr_q == `QESR_OFF_EN_SET)
            en_q <= en_q | wdata_q[`QESR_NUM_EVT-1:0];
        else if (wr_lo && awaddr_q == `QESR_OFF_EN_CLR)
            en_q <= en_q & ~wdata_q[`QESR_NUM_EVT-1:0];
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            irq_q <= 1'b0;
        else
            irq_q <= |(flags_q & en_q);
    end

    // ----------------------------------------------------------------
    // axi4-lite write channels
    // ----------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            aw_full_q <= 1'b0;
            awready_q <= 1'b0;
            awaddr_q  <= '0;
        end
        else if (s_awvalid && awready_q)
        begin
            aw_full_q <= 1'b1;
            awready_q <= 1'b0;
            awaddr_q  <= s_awaddr;
        end
        else if (b_done)
        begin
            aw_full_q <= 1'b0;
            awready_q <= 1'b1;
        end
        else
            awready_q <= ~aw_full_q;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            w_full_q <= 1'b0;
            wready_q <= 1'b0;
            wdata_q  <= `QESR_RST_WORD;
            wstrb_q  <= '0;
        end
        else if (s_wvalid && wready_q)
        begin
            w_full_q <= 1'b1;
            wready_q <= 1'b0;
            wdata_q  <= s_wdata;
            wstrb_q  <= s_wstrb;
        end
        else if (b_done)
        begin
            w_full_q <= 1'b0;
            wready_q <= 1'b1;
        end
        else
            wready_q <= ~w_full_q;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            bvalid_q <= 1'b0;
            bresp_q  <= `QESR_RESP_OKAY;
        end
        else if (do_wr)
        begin
            bvalid_q <= 1'b1;
            bresp_q  <= is_mapped(awaddr_q) ? `QESR_RESP_OKAY : `QESR_RESP_SLVERR;
        end
        else if (b_done)
            bvalid_q <= 1'b0;
    end

    // ----------------------------------------------------------------
    // axi4-lite read channel
    // ----------------------------------------------------------------
    always_comb
    begin
        rd_word = `QESR_RST_WORD;
        for (int i = 0; i < `QESR_NUM_EVT; i++)
        begin
            if (s_araddr == evt_off(i))
                rd_word[0] = flags_q[i];
        end
        case (s_araddr)
            `QESR_OFF_LINKS:  rd_word[`QESR_NUM_LINK-1:0] = links_q;
            `QESR_OFF_EN_SET: rd_word[`QESR_NUM_EVT-1:0] = en_q;
            `QESR_OFF_EN_CLR: rd_word[`QESR_NUM_EVT-1:0] = en_q;
            `QESR_OFF_STATUS: rd_word[`QESR_NUM_EVT-1:0] = flags_q;
            default:          rd_word = rd_word;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= `QESR_RST_WORD;
            rresp_q   <= `QESR_RESP_OKAY;
        end
        else if (s_arvalid && arready_q)
        begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= rd_word;
            rresp_q   <= is_mapped(s_araddr) ? `QESR_RESP_OKAY : `QESR_RESP_SLVERR;
        end
        else if (rvalid_q && s_rready)
        begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
        end
        else
            arready_q <= ~rvalid_q;
    end

    assign s_awready  = awready_q;
    assign s_wready   = wready_q;
    assign s_bvalid   = bvalid_q;
    assign s_bresp    = bresp_q;
    assign s_arready  = arready_q;
    assign s_rvalid   = rvalid_q;
    assign s_rdata    = rdata_q;
    assign s_rresp    = rresp_q;
    assign evt_pulse  = evt_q;
    assign task_pulse = task_q;
    assign irq        = irq_q;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_halt_flag_set: assert property (decoder_halted |=> flags_q.halted)
        else $error("halted flag not set");
    a_links_reset: assert property ($past(rst) |-> links_q == '0)
        else $error("links not zero after reset");
    a_link_a_fire: assert property (
        evt_now.report_ready && links_q.report_read_clear
        |=> task_q.read_clear_accumulator)
        else $error("link A missed");
    a_link_b_stop: assert property (
        evt_now.sample_ready && links_q.sample_stop |=> task_q.stop)
        else $error("link B missed");
    a_link_c_fire: assert property (
        task_q.alt_read_clear_accumulator
        |-> $past(evt_now.report_ready && links_q.report_alt_read_clear))
        else $error("link C spurious");
    a_link_d_stop: assert property (
        evt_now.report_ready && links_q.report_stop |=> task_q.stop)
        else $error("link D missed");
    a_link_e_fire: assert property (
        evt_now.double_ready && links_q.double_read_clear_dbl
        |=> task_q.read_clear_double_accumulator)
        else $error("link E missed");
    a_link_f_stop: assert property (
        evt_now.double_ready && links_q.double_stop |=> task_q.stop)
        else $error("link F missed");
    a_link_g_fire: assert property (
        evt_now.sample_ready && links_q.sample_read_clear
        |=> task_q.read_clear_accumulator)
        else $error("link G missed");
    a_enable_hold: assert property (!do_wr |=> $stable(en_q))
        else $error("enable changed without write");
    a_enable_only_up: assert property (
        do_wr && awaddr_q == `QESR_OFF_EN_SET |=> (en_q & $past(en_q)) == $past(en_q))
        else $error("enable-set dropped a bit");
    a_report_gate: assert property (
        evt_q.report_ready |-> $past(period_done && acc_nonzero))
        else $error("report ready without cause");
    a_double_gate: assert property (
        evt_q.double_ready |-> $past(period_done && dbl_nonzero))
        else $error("double ready without cause");
    a_sample_event: assert property (sample_written |=> evt_q.sample_ready)
        else $error("sample ready missed");
    a_irq_level: assert property (
        irq_q == $past(|(flags_q & en_q)))
        else $error("irq does not follow enabled flags");
    a_bvalid_hold: assert property (bvalid_q && !s_bready |=> bvalid_q)
        else $error("bvalid dropped early");

    c_write_done: cover property (do_wr ##1 b_done);
    c_read_done:  cover property (s_arvalid && arready_q ##1 rvalid_q && s_rready);
    c_irq_rise:   cover property (!irq_q ##1 irq_q);
    c_stop_task:  cover property (task_q.stop);

endmodule

`default_nettype wire

// file: tb/tb_quadrature_event_shortcut_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "qesr_cfg.svh"

module tb_quadrature_event_shortcut_regs
    import qesr_pkg::*;
    ;

    // ----------------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------------
    logic                    mclk           = 1'b0;
    logic                    rst            = 1'b1;
    logic [`QESR_ADDR_W-1:0] s_awaddr       = 12'h000;
    logic                    s_awvalid      = 1'b0;
    logic [31:0]             s_wdata        = 32'h0000_0000;
    logic [3:0]              s_wstrb        = 4'h0;
    logic                    s_wvalid       = 1'b0;
    logic                    s_bready       = 1'b0;
    logic [`QESR_ADDR_W-1:0] s_araddr       = 12'h000;
    logic                    s_arvalid      = 1'b0;
    logic                    s_rready       = 1'b0;
    logic                    sample_written = 1'b0;
    logic                    period_done    = 1'b0;
    logic                    acc_nonzero    = 1'b0;
    logic                    dbl_nonzero    = 1'b0;
    logic                    acc_overflow   = 1'b0;
    logic                    decoder_halted = 1'b0;
    logic                    s_awready;
    logic                    s_wready;
    logic [1:0]              s_bresp;
    logic                    s_bvalid;
    logic                    s_arready;
    logic [31:0]             s_rdata;
    logic [1:0]              s_rresp;
    logic                    s_rvalid;
    qesr_evt_type            evt_pulse;
    qesr_task_type           task_pulse;
    logic                    irq;
    int                      fails          = 0;
    int                      compares       = 0;
    int                      cyc            = 0;
    // event seen for each cause: sample, report, overflow, double, halted, bare period
    logic [4:0]              cause_evt [6]  = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h00};
    // shortcut fields A..G: cause and expected task pulses
    int                      lk_cause [7]   = '{1, 0, 1, 1, 3, 3, 0};
    logic [3:0]              lk_task [7]    = '{4'h8, 4'h1, 4'h4, 4'h1, 4'h2, 4'h1, 4'h8};

    qesr_regs dut_u (.mclk(mclk), .rst(rst), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
        .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
        .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
        .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
        .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
        .sample_written(sample_written), .period_done(period_done),
        .acc_nonzero(acc_nonzero), .dbl_nonzero(dbl_nonzero), .acc_overflow(acc_overflow),
        .decoder_halted(decoder_halted), .evt_pulse(evt_pulse), .task_pulse(task_pulse),
        .irq(irq));

    initial
    begin
        forever #20 mclk = ~mclk;
    end

    // ----------------------------------------------------------------
    // checking and closing
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            $display("unexpected %s expected %h seen %h", nm, exp, got);
            fails++;
        end
    endtask

    task automatic end_of_test();
        $display("fails=%0d compares=%0d", fails, compares);
        if (fails == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fails++;
            end_of_test();
        end
    end

    // ----------------------------------------------------------------
    // register bus tasks
    // ----------------------------------------------------------------
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] st,
                      input logic [1:0] er);
        logic       done;
        logic [1:0] rsp;
        done = 1'b0;
        rsp = 2'h3;
        @(posedge mclk);
        s_awaddr  <= a;
        s_awvalid <= 1'b1;
        s_wdata   <= d;
        s_wstrb   <= st;
        s_wvalid  <= 1'b1;
        s_bready  <= 1'b1;
        // only the cycle ceiling ends a wait that never gets its answer
        while (!done)
        begin
            @(posedge mclk);
            if (s_awvalid && s_awready)
                s_awvalid <= 1'b0;
            if (s_wvalid && s_wready)
                s_wvalid <= 1'b0;
            if (s_bvalid)
            begin
                rsp = s_bresp;
                s_bready <= 1'b0;
                done = 1'b1;
            end
        end
        chk("bresp", 32'(er), 32'(rsp));
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic        done;
        logic [31:0] dat;
        logic [1:0]  rsp;
        done = 1'b0;
        dat = 32'hdead_beef;
        rsp = 2'h3;
        @(posedge mclk);
        s_araddr  <= a;
        s_arvalid <= 1'b1;
        s_rready  <= 1'b1;
        while (!done)
        begin
            @(posedge mclk);
            if (s_arvalid && s_arready)
                s_arvalid <= 1'b0;
            if (s_rvalid)
            begin
                dat = s_rdata;
                rsp = s_rresp;
                s_rready <= 1'b0;
                done = 1'b1;
            end
        end
        chk("rresp", 32'(er), 32'(rsp));
        chk("rdata", ed, dat);
    endtask

    // one-cycle cause, then gather event and task pulses over a short window
    task automatic fire(input int k, input logic [3:0] et);
        logic [4:0] ev;
        logic [3:0] tk;
        ev = 5'h00;
        tk = 4'h0;
        @(posedge mclk);
        sample_written <= (k == 0);
        period_done    <= (k == 1 || k == 3 || k == 5);
        acc_nonzero    <= (k == 1);
        dbl_nonzero    <= (k == 3);
        acc_overflow   <= (k == 2);
        decoder_halted <= (k == 4);
        @(posedge mclk);
        {sample_written, period_done, acc_nonzero} <= 3'h0;
        {dbl_nonzero, acc_overflow, decoder_halted} <= 3'h0;
        // pulses stand only for the cycle after the cause edge, so look right after it
        repeat (5)
        begin
            #1;
            ev = ev | evt_pulse;
            tk = tk | task_pulse;
            @(posedge mclk);
        end
        chk("evt_pulse", 32'(cause_evt[k]), 32'(ev));
        chk("task_pulse", 32'(et), 32'(tk));
    endtask

    task automatic irq_is(input logic e);
        repeat (2) @(posedge mclk);
        #1;
        chk("irq", 32'(e), 32'(irq));
    endtask

    // ----------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
        rd(`QESR_OFF_HALTED, 32'h0, `QESR_RESP_OKAY);
        rd(`QESR_OFF_LINKS, 32'h0, `QESR_RESP_OKAY);
        rd(`QESR_OFF_EN_SET, 32'h0, `QESR_RESP_OKAY);
        rd(`QESR_OFF_EN_CLR, 32'h0, `QESR_RESP_OKAY);
        rd(12'hff0, 32'h0, `QESR_RESP_SLVERR);
        wr(12'hff0, 32'h1, 4'hf, `QESR_RESP_SLVERR);
        fire(4, 4'h0);
        rd(`QESR_OFF_HALTED, 32'h1, `QESR_RESP_OKAY);
        wr(`QESR_OFF_HALTED, 32'h0, 4'hf, `QESR_RESP_OKAY);
        rd(`QESR_OFF_HALTED, 32'h0, `QESR_RESP_OKAY);
        fire(0, 4'h0);
        fire(1, 4'h0);
        fire(5, 4'h0);
        fire(3, 4'h0);
        for (int i = 0; i < 7; i++)
        begin
            wr(`QESR_OFF_LINKS, 32'h1 << i, 4'hf, `QESR_RESP_OKAY);
            fire(lk_cause[i], lk_task[i]);
        end
        wr(`QESR_OFF_LINKS, 32'hffff_ffff, 4'hf, `QESR_RESP_OKAY);
        rd(`QESR_OFF_LINKS, 32'h7f, `QESR_RESP_OKAY);
        fire(1, 4'hd);
        wr(`QESR_OFF_LINKS, 32'h0, 4'he, `QESR_RESP_OKAY);
        rd(`QESR_OFF_LINKS, 32'h7f, `QESR_RESP_OKAY);
        wr(`QESR_OFF_LINKS, 32'h0, 4'hf, `QESR_RESP_OKAY);
        fire(3, 4'h0);
        wr(`QESR_OFF_STAT_CLR, 32'h1f, 4'hf, `QESR_RESP_OKAY);
        irq_is(1'b0);
        // masked flag, then enable and disable
        for (int i = 0; i < 5; i++)
        begin
            fire(i, 4'h0);
            irq_is(1'b0);
            rd(`QESR_OFF_STATUS, 32'h1 << i, `QESR_RESP_OKAY);
            wr(`QESR_OFF_EN_SET, 32'h1 << i, 4'hf, `QESR_RESP_OKAY);
            irq_is(1'b1);
            wr(`QESR_OFF_EN_SET, 32'h0, 4'hf, `QESR_RESP_OKAY);
            rd(`QESR_OFF_EN_SET, 32'h1 << i, `QESR_RESP_OKAY);
            rd(`QESR_OFF_EN_CLR, 32'h1 << i, `QESR_RESP_OKAY);
            wr(`QESR_OFF_EN_CLR, 32'h1 << i, 4'hf, `QESR_RESP_OKAY);
            irq_is(1'b0);
            rd(`QESR_OFF_EN_SET, 32'h0, `QESR_RESP_OKAY);
            wr(`QESR_OFF_STAT_CLR, 32'h1f, 4'hf, `QESR_RESP_OKAY);
        end
        wr(`QESR_OFF_EN_SET, 32'h1f, 4'hf, `QESR_RESP_OKAY);
        rd(`QESR_OFF_EN_SET, 32'h1f, `QESR_RESP_OKAY);
        irq_is(1'b0);
        fire(2, 4'h0);
        irq_is(1'b1);
        wr(`QESR_OFF_STAT_CLR, 32'h1f, 4'hf, `QESR_RESP_OKAY);
        irq_is(1'b0);
        end_of_test();
    end

endmodule

`default_nettype wire
